// ### rtl/vic_pkg.sv
// constants, field layout and carrier types of the vectored interrupt controller
// assumes word-addressed register access: word index equals the printed offset
package vic_pkg;

    // ************************************************************
    // register word indexes (byte address is four times the index)
    // ************************************************************
    localparam logic [7:0] GEN_MASK_INDEX = 8'h3B;
    localparam logic [7:0] GEN_FLAG_INDEX = 8'h3A;
    localparam logic [7:0] TIMER_MASK_INDEX = 8'h39;
    localparam logic [7:0] TIMER_FLAG_INDEX = 8'h38;
    localparam logic [7:0] SENSE_CTRL_INDEX = 8'h35;
    localparam logic [7:0] STATUS_INDEX = 8'h3F;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int EXT_BIT = 6;
    localparam int PC_HIGH_BIT = 5;
    localparam int PC_LOW_BIT = 4;
    localparam int PC_FLAG_BIT = 5;
    localparam int GIE_BIT = 7;
    localparam int TMR_POS [0:3] = '{6, 5, 2, 1};
    localparam logic [7:0] GEN_MASK_WRITABLE = 8'h70;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] SENSE_RESET = 2'h0;
    localparam logic [1:0] SENSE_LOW = 2'h0;
    localparam logic [1:0] SENSE_ANY = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_RISE = 2'h3;

    // ************************************************************
    // sizes and cycle counts
    // ************************************************************
    localparam int SOURCE_COUNT = 11;
    localparam int PC_W = 10;
    localparam int PIN_COUNT = 11;
    localparam int LOW_PIN_COUNT = 4;
    localparam logic [2:0] ENTRY_CYCLES = 3'h4;
    localparam logic [2:0] JUMP_CYCLES = 3'h2;
    localparam logic [2:0] RETURN_CYCLES = 3'h4;

    // ************************************************************
    // carriers toward and from the core sequencer
    // ************************************************************
    typedef struct packed {
        logic instr_boundary;
        logic return_from_interrupt_exec;
        logic [9:0] pc;
        logic [7:0] stack_rdata;
    } core_in_type;

    typedef struct packed {
        logic busy;
        logic stack_push;
        logic [7:0] stack_wdata;
        logic stack_pop;
        logic vector_load;
        logic [9:0] vector_addr;
        logic pc_restore;
        logic [9:0] restore_pc;
    } core_out_type;

endpackage : vic_pkg

// ### rtl/vectored_interrupt_controller.sv
// fixed-priority vectored interrupt controller with avalon-mm registers
// assumes the core reports instruction boundaries and return execution,
// and that peripheral requests arrive synchronous to mclk
//
// Notes on behaviour
// - eleven request sources besides reset, each with its own vector
// - serve a request only when global enable is set and, except for the five peripheral requests, its enable is set
// - vectors: reset 0x000, then the eleven sources up to 0x00B
// - lowest vector address wins among pending requests
// - accepting an interrupt clears global enable
// - return sets global enable; software may set it for nesting
// - loading the vector clears the flag of the served source
// - writing one to a flag clears it; zero leaves it
// - flags set even while their enable is clear, except the pin-change flag
// - flags wait while global enable is clear, then serve by priority
// - level external request has no flag, acts only while asserted
// - status register is never saved or restored by hardware
// - entry takes four cycles, pushing the ten-bit program counter
// - jump from vector to handler takes two cycles
// - multicycle instruction finishes before entry begins
// - return takes four cycles, popping the ten-bit program counter
// - one main-program instruction runs after return before next entry
// - two separate 8-bit mask registers: general and timer
// - bit 7 of the general mask reads as zero
// - external flag set by pin event, cleared, kept clear in level mode
// - pin-change enables gate their pins from setting the shared flag
// - timer flags clear one cycle after a write of one
`timescale 1ns/100ps

module vectored_interrupt_controller #(
    parameter int ADDR_W = 8
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic external_request_zero,
    input wire logic [10:0] change_pins,
    input wire logic [10:0] change_alt_mask,
    input wire logic [3:0] timer_event,
    input wire logic [4:0] periph_request,
    output logic [10:0] source_ack,
    input wire vic_pkg::core_in_type core_in,
    output vic_pkg::core_out_type core_out
);

    // ************************************************************
    // state declarations
    // ************************************************************
    typedef enum logic [1:0] {ST_IDLE, ST_ENTRY, ST_JUMP, ST_RETURN} seq_state_type;

    seq_state_type state;
    logic [2:0] cnt;
    logic [7:0] general_interrupt_mask;
    logic [3:0] timer_source_mask;
    logic [1:0] sense_mode;
    logic gie;
    logic external_request_flag;
    logic pin_change_flag;
    logic [3:0] timer_flag;
    logic [3:0] timer_clear_pend;
    logic ext_prev;
    logic [10:0] pins_prev;
    logic after_return_from_interrupt;
    logic [3:0] served_idx;
    logic [9:0] saved_pc;
    logic [9:0] popped_pc;
    logic [10:0] request;
    logic any_request;
    logic [3:0] next_idx;
    logic start_entry;
    logic entry_done;
    logic return_done;
    logic [10:0] vector_clear;
    logic wr_go;
    logic [7:0] wdata;
    logic [7:0] read_value;
    logic ext_event;
    logic pin_event;
    logic [10:0] pin_enable;

    // ************************************************************
    // avalon slave
    // ************************************************************

    // a write takes effect only in the cycle waitrequest is low
    assign wr_go = avs_write & ~avs_waitrequest & avs_byteenable[0];
    assign wdata = avs_writedata[7:0];

    // one wait cycle per access, then a single answer cycle
    always_ff @(posedge mclk) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read | avs_write) & avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // read mux; unmapped words read as zero
    always_comb begin
        read_value = 8'h00;
        case (avs_address[7:0])
            vic_pkg::GEN_MASK_INDEX: begin
                read_value = general_interrupt_mask & vic_pkg::GEN_MASK_WRITABLE;
            end
            vic_pkg::GEN_FLAG_INDEX: begin
                read_value[vic_pkg::EXT_BIT] = external_request_flag;
                read_value[vic_pkg::PC_FLAG_BIT] = pin_change_flag;
            end
            vic_pkg::TIMER_MASK_INDEX: begin
                for (int i = 0; i < 4; i++) begin
                    read_value[vic_pkg::TMR_POS[i]] = timer_source_mask[i];
                end
            end
            vic_pkg::TIMER_FLAG_INDEX: begin
                for (int i = 0; i < 4; i++) begin
                    read_value[vic_pkg::TMR_POS[i]] = timer_flag[i];
                end
            end
            vic_pkg::SENSE_CTRL_INDEX: begin
                read_value[1:0] = sense_mode;
            end
            vic_pkg::STATUS_INDEX: begin
                read_value[vic_pkg::GIE_BIT] = gie;
            end
            default: begin
                read_value = 8'h00;
            end
        endcase
    end

    // read data captured in the wait cycle
    always_ff @(posedge mclk) begin
        if (reset) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read & avs_waitrequest) begin
            avs_readdata <= {24'h00_0000, read_value};
        end
    end

    // ************************************************************
    // mask and control registers
    // ************************************************************

    always_ff @(posedge mclk) begin
        if (reset) begin
            general_interrupt_mask <= vic_pkg::REG_RESET;
            timer_source_mask <= 4'h0;
            sense_mode <= vic_pkg::SENSE_RESET;
        end else if (wr_go) begin
            if (avs_address[7:0] == vic_pkg::GEN_MASK_INDEX) begin
                general_interrupt_mask <= wdata & vic_pkg::GEN_MASK_WRITABLE;
            end
            if (avs_address[7:0] == vic_pkg::TIMER_MASK_INDEX) begin
                for (int i = 0; i < 4; i++) begin
                    timer_source_mask[i] <= wdata[vic_pkg::TMR_POS[i]];
                end
            end
            if (avs_address[7:0] == vic_pkg::SENSE_CTRL_INDEX) begin
                sense_mode <= wdata[1:0];
            end
        end
    end

    // global enable; only status bit held here
    always_ff @(posedge mclk) begin
        if (reset) begin
            gie <= 1'b0;
        end else if (start_entry) begin
            gie <= 1'b0;
        end else if (return_done) begin
            gie <= 1'b1;
        end else if (wr_go && avs_address[7:0] == vic_pkg::STATUS_INDEX) begin
            gie <= wdata[vic_pkg::GIE_BIT];
        end
    end

    // ************************************************************
    // request flags
    // ************************************************************

    // previous pin levels for edge and change detection
    always_ff @(posedge mclk) begin
        if (reset) begin
            ext_prev <= 1'b1;
            pins_prev <= 11'h000;
        end else begin
            ext_prev <= external_request_zero;
            pins_prev <= change_pins;
        end
    end

    always_comb begin
        case (sense_mode)
            vic_pkg::SENSE_ANY: ext_event = external_request_zero ^ ext_prev;
            vic_pkg::SENSE_FALL: ext_event = ~external_request_zero & ext_prev;
            vic_pkg::SENSE_RISE: ext_event = external_request_zero & ~ext_prev;
            default: ext_event = 1'b0;
        endcase
    end

    assign pin_enable = {{(vic_pkg::PIN_COUNT - vic_pkg::LOW_PIN_COUNT)
                          {general_interrupt_mask[vic_pkg::PC_HIGH_BIT]}},
                         {vic_pkg::LOW_PIN_COUNT{general_interrupt_mask[vic_pkg::PC_LOW_BIT]}}};
    assign pin_event = |((change_pins ^ pins_prev) & ~change_alt_mask & pin_enable);

    // external flag: set wins over clears
    always_ff @(posedge mclk) begin
        if (reset) begin
            external_request_flag <= 1'b0;
        end else if (sense_mode == vic_pkg::SENSE_LOW) begin
            external_request_flag <= 1'b0;
        end else if (ext_event) begin
            external_request_flag <= 1'b1;
        end else if (vector_clear[0]) begin
            external_request_flag <= 1'b0;
        end else if (wr_go && avs_address[7:0] == vic_pkg::GEN_FLAG_INDEX
                     && wdata[vic_pkg::EXT_BIT]) begin
            external_request_flag <= 1'b0;
        end
    end

    // shared pin-change flag
    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_change_flag <= 1'b0;
        end else if (pin_event) begin
            pin_change_flag <= 1'b1;
        end else if (vector_clear[1]) begin
            pin_change_flag <= 1'b0;
        end else if (wr_go && avs_address[7:0] == vic_pkg::GEN_FLAG_INDEX
                     && wdata[vic_pkg::PC_FLAG_BIT]) begin
            pin_change_flag <= 1'b0;
        end
    end

    // timer flags; write-one clear lands a cycle late
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_timer
            always_ff @(posedge mclk) begin
                if (reset) begin
                    timer_flag[g] <= 1'b0;
                    timer_clear_pend[g] <= 1'b0;
                end else begin
                    timer_clear_pend[g] <= wr_go
                        && avs_address[7:0] == vic_pkg::TIMER_FLAG_INDEX
                        && wdata[vic_pkg::TMR_POS[g]];
                    if (timer_event[g]) begin
                        timer_flag[g] <= 1'b1;
                    end else if (vector_clear[g+2] | timer_clear_pend[g]) begin
                        timer_flag[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // request gating and priority
    // ************************************************************

    always_comb begin
        if (sense_mode == vic_pkg::SENSE_LOW) begin
            request[0] = ~external_request_zero & general_interrupt_mask[vic_pkg::EXT_BIT];
        end else begin
            request[0] = external_request_flag & general_interrupt_mask[vic_pkg::EXT_BIT];
        end
        request[1] = pin_change_flag & (general_interrupt_mask[vic_pkg::PC_HIGH_BIT]
                                        | general_interrupt_mask[vic_pkg::PC_LOW_BIT]);
        request[5:2] = timer_flag & timer_source_mask;
        request[10:6] = periph_request;
    end

    always_comb begin
        next_idx = 4'h0;
        for (int i = vic_pkg::SOURCE_COUNT - 1; i >= 0; i--) begin
            if (request[i]) begin
                next_idx = 4'(i);
            end
        end
    end
    assign any_request = |request;

    // ************************************************************
    // entry and return sequencer
    // ************************************************************

    assign start_entry = state == ST_IDLE && any_request && gie
                         && core_in.instr_boundary && !after_return_from_interrupt;
    assign entry_done = state == ST_ENTRY && cnt == vic_pkg::ENTRY_CYCLES - 3'h1;
    assign return_done = state == ST_RETURN && cnt == vic_pkg::RETURN_CYCLES - 3'h1;
    assign vector_clear = entry_done ? 11'(11'h001 << served_idx) : 11'h000;

    // first boundary after return ends the hold
    always_ff @(posedge mclk) begin
        if (reset) begin
            after_return_from_interrupt <= 1'b0;
        end else if (return_done) begin
            after_return_from_interrupt <= 1'b1;
        end else if (state == ST_IDLE && core_in.instr_boundary) begin
            after_return_from_interrupt <= 1'b0;
        end
    end

    // state, counter and registered core outputs; the status word is
    // left to software
    // status not stacked
    always_ff @(posedge mclk) begin
        if (reset) begin
            state <= ST_IDLE;
            cnt <= 3'h0;
            served_idx <= 4'h0;
            saved_pc <= 10'h000;
            popped_pc <= 10'h000;
            core_out <= '0;
            source_ack <= 11'h000;
        end else begin
            core_out.stack_push <= 1'b0;
            core_out.stack_pop <= 1'b0;
            core_out.vector_load <= 1'b0;
            core_out.pc_restore <= 1'b0;
            source_ack <= vector_clear;
            cnt <= cnt + 3'h1;
            case (state)
                ST_IDLE: begin
                    cnt <= 3'h0;
                    if (start_entry) begin
                        state <= ST_ENTRY;
                        served_idx <= next_idx;
                        saved_pc <= core_in.pc;
                        core_out.busy <= 1'b1;
                        core_out.stack_push <= 1'b1;
                        core_out.stack_wdata <= core_in.pc[7:0];
                    end else if (core_in.return_from_interrupt_exec) begin
                        state <= ST_RETURN;
                        core_out.busy <= 1'b1;
                        core_out.stack_pop <= 1'b1;
                    end
                end
                ST_ENTRY: begin
                    if (cnt == 3'h0) begin
                        core_out.stack_push <= 1'b1;
                        core_out.stack_wdata <= {6'h00, saved_pc[9:8]};
                    end
                    if (entry_done) begin
                        state <= ST_JUMP;
                        cnt <= 3'h0;
                        core_out.vector_load <= 1'b1;
                        core_out.vector_addr <= 10'(served_idx) + 10'h001;
                    end
                end
                ST_JUMP: begin
                    if (cnt == vic_pkg::JUMP_CYCLES - 3'h1) begin
                        state <= ST_IDLE;
                        core_out.busy <= 1'b0;
                    end
                end
                ST_RETURN: begin
                    if (cnt == 3'h0) begin
                        core_out.stack_pop <= 1'b1;
                    end
                    if (cnt == 3'h1) begin
                        popped_pc[9:8] <= core_in.stack_rdata[1:0];
                    end
                    if (cnt == 3'h2) begin
                        popped_pc[7:0] <= core_in.stack_rdata;
                    end
                    if (return_done) begin
                        state <= ST_IDLE;
                        core_out.busy <= 1'b0;
                        core_out.pc_restore <= 1'b1;
                        core_out.restore_pc <= popped_pc;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    core_out.busy <= 1'b0;
                end
            endcase
        end
    end

endmodule : vectored_interrupt_controller

// ### tb/vic_props.sv
// checker of bus handshake and core sequencing
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/100ps

module vic_props (
    input wire logic mclk,
    input wire logic reset,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic [10:0] source_ack,
    input wire vic_pkg::core_out_type core_out
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    // ********************************
    // bus handshake and core sequencing
    // ********************************
    a_wait_single: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("wait low too long");
    a_wait_answer: assert property ($rose(avs_read || avs_write) |->
        avs_waitrequest ##1 !avs_waitrequest) else $error("no answer");
    a_wait_idle: assert property (!avs_read && !avs_write |=> avs_waitrequest)
        else $error("idle wait low");
    a_entry_order: assert property ($rose(core_out.stack_push) |=>
        core_out.stack_push && core_out.stack_wdata[7:2] == 6'h00 ##1 !core_out.stack_push
        ##[1:2] core_out.vector_load) else $error("bad entry");
    a_vector_ack: assert property (core_out.vector_load |->
        core_out.vector_addr inside {[10'h001:10'h00B]} &&
        source_ack == 11'h001 << (core_out.vector_addr - 10'h001)) else $error("bad vector or ack");
    a_ack_load: assert property (|source_ack |-> core_out.vector_load)
        else $error("stray ack");
    a_return_order: assert property ($rose(core_out.stack_pop) |=>
        core_out.stack_pop ##[1:3] core_out.pc_restore) else $error("bad return");
    a_return_gap: assert property (core_out.pc_restore |->
        !core_out.stack_push ##1 !core_out.stack_push) else $error("early entry");
    a_push_busy: assert property (core_out.stack_push || core_out.vector_load |->
        core_out.busy) else $error("not busy");
    a_load_pulse: assert property (core_out.vector_load |=> !core_out.vector_load)
        else $error("long load");
    c_entry: cover property (core_out.vector_load);
    c_return: cover property (core_out.pc_restore);
    c_read: cover property (avs_read && !avs_waitrequest);
endmodule : vic_props

// ### tb/core_model.sv
// core sequencer model: stack memory, program counter, return instruction
// assumes single-cycle instructions, so every cycle is a boundary
`timescale 1ns/100ps

module core_model (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ret_hold,
    input wire vic_pkg::core_out_type core_out,
    output vic_pkg::core_in_type core_in
);
    logic [7:0] stack_mem [0:7];
    logic [2:0] sp;
    logic [7:0] rdata_q;
    logic [9:0] pc_q;
    logic return_from_interrupt_q;
    logic ret_owed;

    // ****************
    // stack and return
    // ****************
    assign core_in = '{instr_boundary: 1'b1, return_from_interrupt_exec: return_from_interrupt_q, pc: pc_q, stack_rdata: rdata_q};

    always_ff @(posedge mclk) begin
        if (reset) begin
            sp <= 3'h0;
            rdata_q <= 8'h00;
        end else if (core_out.stack_pop) begin
            sp <= sp - 3'h1;
            rdata_q <= stack_mem[sp - 3'h1];
        end else begin
            // stale byte inverted so a late sample cannot pass
            rdata_q <= ~rdata_q;
            if (core_out.stack_push) begin
                stack_mem[sp] <= core_out.stack_wdata;
                sp <= sp + 3'h1;
            end
        end
    end

    // status untouched; main code at one pc
    always_ff @(posedge mclk) begin
        if (reset) begin
            pc_q <= 10'h2A5;
            ret_owed <= 1'b0;
            return_from_interrupt_q <= 1'b0;
        end else begin
            return_from_interrupt_q <= ret_owed && !core_out.busy && !ret_hold && !return_from_interrupt_q;
            if (core_out.vector_load) begin
                pc_q <= core_out.vector_addr;
                ret_owed <= 1'b1;
            end else if (core_out.pc_restore) begin
                pc_q <= core_out.restore_pc;
            end else if (return_from_interrupt_q) begin
                ret_owed <= 1'b0;
            end
        end
    end
endmodule : core_model

// ### tb/vectored_interrupt_controller_bench.sv
// self-checking bench of the vectored interrupt controller
// assumes the core model returns unless held
`timescale 1ns/100ps

module vectored_interrupt_controller_bench;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic external_request_zero = 1'b1;
    logic [10:0] change_pins = 11'h000;
    logic [10:0] change_alt_mask = 11'h000;
    logic [3:0] timer_event = 4'h0;
    logic [4:0] periph_request = 5'h00;
    logic [10:0] source_ack;
    logic ret_hold = 1'b0;
    vic_pkg::core_in_type core_in;
    vic_pkg::core_out_type core_out;
    logic [31:0] rv;
    int n_mismatch = 0;
    int checked = 0;
    int n_vec = 0;
    int cycles = 0;

    vectored_interrupt_controller dut_u (
        .mclk(mclk),
        .reset(reset),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .external_request_zero(external_request_zero),
        .change_pins(change_pins),
        .change_alt_mask(change_alt_mask),
        .timer_event(timer_event),
        .periph_request(periph_request),
        .source_ack(source_ack),
        .core_in(core_in),
        .core_out(core_out)
    );
    core_model partner_u (
        .mclk(mclk),
        .reset(reset),
        .ret_hold(ret_hold),
        .core_out(core_out),
        .core_in(core_in)
    );

    // ************************
    // clock, timeout, peripherals
    // ************************
    always #2 mclk = ~mclk;
    // peripherals drop acked levels; ceiling ends hangs
    always @(posedge mclk) begin
        cycles++;
        if (core_out.vector_load === 1'b1) n_vec++;
        if (|source_ack[10:6]) periph_request <= periph_request & ~source_ack[10:6];
        if (cycles == 20000) begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one avalon access; read data land in rv
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        avs_address <= idx;
        avs_writedata <= {24'h000000, wd};
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0 && n++ < 50);
        rv = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask : bus

    task automatic vec(input logic [31:0] exp);
        int n;
        n = 0;
        do @(posedge mclk); while (core_out.vector_load !== 1'b1 && n++ < 100);
        check("vector", core_out.vector_addr, exp);
        check("ack", source_ack, 32'h1 << (exp - 32'h1));
    endtask : vec

    task automatic back;
        int n;
        n = 0;
        do @(posedge mclk); while (core_out.pc_restore !== 1'b1 && n++ < 100);
        check("restore pc", core_out.restore_pc, 32'h2A5);
    endtask : back

    task automatic t_regs;
        bus(1'b0, vic_pkg::GEN_MASK_INDEX, 8'h00);
        check("mask reset", rv, 32'h0);
        bus(1'b1, vic_pkg::GEN_MASK_INDEX, 8'hFF);
        bus(1'b0, vic_pkg::GEN_MASK_INDEX, 8'h00);
        check("gen mask", rv, 32'h70);
        bus(1'b1, vic_pkg::TIMER_MASK_INDEX, 8'hFF);
        bus(1'b0, vic_pkg::TIMER_MASK_INDEX, 8'h00);
        check("timer mask", rv, 32'h66);
        bus(1'b1, 8'h10, 8'hFF);
        bus(1'b0, 8'h10, 8'h00);
        check("unmapped", rv, 32'h0);
        bus(1'b1, vic_pkg::GEN_MASK_INDEX, 8'h00);
        bus(1'b1, vic_pkg::TIMER_MASK_INDEX, 8'h00);
        $display("test regs done");
    endtask : t_regs

    task automatic t_pending;
        timer_event <= 4'hF;
        @(posedge mclk);
        timer_event <= 4'h0;
        periph_request <= 5'h11;
        bus(1'b0, vic_pkg::TIMER_FLAG_INDEX, 8'h00);
        check("flags", rv, 32'h66);
        bus(1'b1, vic_pkg::TIMER_FLAG_INDEX, 8'h40);
        bus(1'b0, vic_pkg::TIMER_FLAG_INDEX, 8'h00);
        check("flag clear", rv, 32'h26);
        ret_hold <= 1'b1;
        bus(1'b1, vic_pkg::TIMER_MASK_INDEX, 8'hFF);
        bus(1'b1, vic_pkg::STATUS_INDEX, 8'h80);
        vec(32'h4);
        bus(1'b0, vic_pkg::STATUS_INDEX, 8'h00);
        check("gie", rv, 32'h0);
        bus(1'b0, vic_pkg::TIMER_FLAG_INDEX, 8'h00);
        check("served flag", rv, 32'h06);
        ret_hold <= 1'b0;
        back();
        // rest follow by priority
        vec(32'h5);
        back();
        vec(32'h6);
        back();
        vec(32'h7);
        back();
        vec(32'hB);
        back();
        $display("test pending done");
    endtask : t_pending

    task automatic t_external;
        external_request_zero <= 1'b0;
        repeat (40) @(posedge mclk);
        check("no entry", n_vec, 32'h5);
        bus(1'b0, vic_pkg::GEN_FLAG_INDEX, 8'h00);
        check("level no flag", rv, 32'h0);
        bus(1'b1, vic_pkg::GEN_MASK_INDEX, 8'h40);
        vec(32'h1);
        external_request_zero <= 1'b1;
        back();
        bus(1'b1, vic_pkg::GEN_MASK_INDEX, 8'h00);
        bus(1'b1, vic_pkg::SENSE_CTRL_INDEX, {6'h00, vic_pkg::SENSE_FALL});
        external_request_zero <= 1'b0;
        @(posedge mclk);
        external_request_zero <= 1'b1;
        bus(1'b0, vic_pkg::GEN_FLAG_INDEX, 8'h00);
        check("edge flag", rv, 32'h40);
        bus(1'b1, vic_pkg::GEN_FLAG_INDEX, 8'h40);
        bus(1'b0, vic_pkg::GEN_FLAG_INDEX, 8'h00);
        check("edge flag clear", rv, 32'h0);
        $display("test external done");
    endtask : t_external

    task automatic t_pins;
        bus(1'b1, vic_pkg::GEN_MASK_INDEX, 8'h10);
        change_pins <= 11'h020;
        bus(1'b0, vic_pkg::GEN_FLAG_INDEX, 8'h00);
        check("high off", rv, 32'h0);
        change_pins <= 11'h022;
        vec(32'h2);
        back();
        change_alt_mask <= 11'h002;
        change_pins <= 11'h020;
        repeat (20) @(posedge mclk);
        check("alt pin", n_vec, 32'h7);
        $display("test pins done");
    endtask : t_pins

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        t_regs();
        t_pending();
        t_external();
        t_pins();
        conclude();
    end
endmodule : vectored_interrupt_controller_bench

bind vectored_interrupt_controller vic_props props_u (.*);
